// >>> frbs_pkg.sv
package frbs_pkg;

    // Sequencer clock rate.
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CLK_NS = 40;

    // Timing limits after the fundamental reset condition clears.
    localparam int unsigned LINK_ACTIVE_MAX_MS = 20;
    localparam int unsigned CFG_RETRY_MAX_MS = 100;
    localparam int unsigned LINK_ACTIVE_MAX_CYC = LINK_ACTIVE_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned CFG_RETRY_MAX_CYC = CFG_RETRY_MAX_MS * (CLK_HZ / 1000);

    // Serial management bus rates.
    localparam int unsigned MBUS_SLOW_HZ = 100000;
    localparam int unsigned MBUS_FAST_HZ = 400000;
    localparam int unsigned MBUS_SLOW_DIV = CLK_HZ / MBUS_SLOW_HZ;
    localparam int unsigned MBUS_FAST_DIV = CLK_HZ / MBUS_FAST_HZ;

    // Operating mode encodings.
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_EEPROM = 3'h1;

    // Boot vector layout in the switch status word.
    localparam int unsigned BOOT_MODE_LSB = 0;
    localparam int unsigned BOOT_CCDS_BIT = 3;
    localparam int unsigned BOOT_CCUS_BIT = 4;
    localparam int unsigned BOOT_MSPD_BIT = 5;
    localparam int unsigned BOOT_SADDR_LSB = 6;
    localparam int unsigned BOOT_W = 10;
    localparam logic [BOOT_W-1:0] BOOT_RESET = 10'h000;

    // Slave address field built from straps 5 and 3..1.
    localparam int unsigned SADDR_W = 4;
    localparam logic [6:0] SADDR_BASE = 7'h00;

    // Serial bus status layout.
    localparam int unsigned SBS_ERR_W = 4;
    localparam int unsigned SBS_DONE_BIT = 4;
    localparam logic [4:0] SBS_RESET = 5'h00;

    typedef enum logic [3:0] {
        FRBS_HOLD,
        FRBS_DECODE,
        FRBS_PLL,
        FRBS_SLAVE,
        FRBS_MASTER,
        FRBS_EEPROM,
        FRBS_ACK,
        FRBS_RUN
    } frbs_state_type;

endpackage : frbs_pkg

// >>> frbs_sequencer.sv
// Overview of operation
// - Capture boot vector on reset release.
// - Boot inputs ignored outside fundamental reset.
// - Hold captured boot vector in status.
// - Downstream strap sets downstream slot-clock reset.
// - Upstream strap sets upstream slot-clock reset.
// - Reset input resets logic, starts sequence.
// - Mode 0 normal, 1 EEPROM, others reserved.
// - Hot reset clears all but sticky fields; here it only drives portHotReset and clears no register.
// - Secondary bus reset spares upstream bridge.
// - Pin reset or control bit starts sequence.
// - Software warm reset reuses earlier boot samples.
// - Reset PLL, await lock, then train links.
// - Links active within 20ms of release.
// - Config retry answers within 100ms of release.
// - Master bus 100KHz if strap, else 400KHz.
// - Slave leaves reset with address straps, master next.
// - EEPROM mode loads registers from EEPROM.
// - EEPROM retrain bit write retrains that port.
// - Load error aborts, records, sets done flag.
// - Retry completions while EEPROM load runs.
// - Complete reset-bit write before warm reset.
`timescale 1ns/1ps
`default_nettype none
module frbs_sequencer
    import frbs_pkg::*;
#(
    parameter int unsigned PORTS = 4,
    parameter int unsigned LINK_ACTIVE_CYC = LINK_ACTIVE_MAX_CYC,
    parameter int unsigned CFG_RETRY_CYC = CFG_RETRY_MAX_CYC
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic fundamentalResetN,
    input wire logic [2:0] operatingModeStraps,
    input wire logic commonClockDownstreamStrap,
    input wire logic commonClockUpstreamStrap,
    input wire logic masterBusSpeedStrap,
    input wire logic [SADDR_W-1:0] slaveBusAddressStraps,
    input wire logic fundamentalResetCtlWrite,
    input wire logic hotReset,
    input wire logic secondaryBusReset,
    input wire logic pllLock,
    input wire logic [PORTS-1:0] slotClockWrite,
    input wire logic [PORTS-1:0] slotClockWriteData,
    input wire logic eepromLoadDone,
    input wire logic eepromLoadError,
    input wire logic [SBS_ERR_W-1:0] eepromErrorCode,
    input wire logic [PORTS-1:0] fullLinkRetrainWrite,
    output logic pllReset,
    output logic linkTrainEnable,
    output logic stackReset,
    output logic cfgRetryMode,
    output logic [PORTS-1:0] portHotReset,
    output logic [PORTS-1:0] portRetrain,
    output logic slaveBusEnable,
    output logic [6:0] slaveBusAddress,
    output logic masterBusEnable,
    output logic [15:0] masterBusDivider,
    output logic eepromLoadStart,
    output logic fundamentalResetCtlAck,
    output logic [BOOT_W-1:0] switchStatus,
    output logic [PORTS-1:0] slotClockConfig,
    output logic [4:0] serialBusStatus,
    output logic modeReserved,
    output logic sequenceDone
);

    frbs_state_type state_r;
    logic [1:0] rstSync_r;
    logic [1:0] lockSync_r;
    logic pinRstPrev_r;
    logic pinCapture_r;
    logic [BOOT_W-1:0] boot_r;
    logic [31:0] sinceRelease_r;
    logic swReset_r;

    // Straps and the reset pin come from the board, so they are resynchronised.
    logic [2:0] modeS1_r, modeS2_r;
    logic ccdsS1_r, ccdsS2_r, ccusS1_r, ccusS2_r, mspdS1_r, mspdS2_r;
    logic [SADDR_W-1:0] saddrS1_r, saddrS2_r;

    function automatic logic [15:0] frbs_divider(input logic slow);
        frbs_divider = slow ? 16'(MBUS_SLOW_DIV) : 16'(MBUS_FAST_DIV);
    endfunction

    always_ff @(posedge clk)
    begin
        rstSync_r <= {rstSync_r[0], fundamentalResetN};
        lockSync_r <= {lockSync_r[0], pllLock};
        modeS1_r <= operatingModeStraps;
        modeS2_r <= modeS1_r;
        ccdsS1_r <= commonClockDownstreamStrap;
        ccdsS2_r <= ccdsS1_r;
        ccusS1_r <= commonClockUpstreamStrap;
        ccusS2_r <= ccusS1_r;
        mspdS1_r <= masterBusSpeedStrap;
        mspdS2_r <= mspdS1_r;
        saddrS1_r <= slaveBusAddressStraps;
        saddrS2_r <= saddrS1_r;
    end

    wire pinAsserted = !rstSync_r[1];
    wire pinRelease = pinRstPrev_r && !pinAsserted;

    // A pin reset holds the sequence in FRBS_HOLD; its release captures a fresh boot vector.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pinRstPrev_r <= 1'b1;
            pinCapture_r <= 1'b0;
        end
        else
        begin
            pinRstPrev_r <= pinAsserted;
            if (pinAsserted || pinRelease)
                pinCapture_r <= 1'b1;
            else if (state_r == FRBS_DECODE)
                pinCapture_r <= 1'b0;
        end
    end

    // Boot vector changes only on pin release; software resets reuse it.
    always_ff @(posedge clk)
    begin
        if (reset)
            boot_r <= BOOT_RESET;
        else if (pinRelease)
            boot_r <= {saddrS2_r, mspdS2_r, ccusS2_r, ccdsS2_r, modeS2_r};
    end

    // Software request is acknowledged first, then the warm reset runs.
    always_ff @(posedge clk)
    begin
        if (reset || pinAsserted)
            swReset_r <= 1'b0;
        else if (fundamentalResetCtlWrite && state_r == FRBS_RUN)
            swReset_r <= 1'b1;
        else if (state_r == FRBS_ACK)
            swReset_r <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset || pinAsserted)
            state_r <= FRBS_HOLD;
        else
        begin
            case (state_r)
                FRBS_HOLD: if (!lockSync_r[1]) state_r <= FRBS_DECODE;
                FRBS_DECODE: state_r <= FRBS_PLL;
                FRBS_PLL:
                    if (lockSync_r[1])
                        state_r <= FRBS_SLAVE;
                FRBS_SLAVE: state_r <= FRBS_MASTER;
                FRBS_MASTER:
                    state_r <= (boot_r[BOOT_MODE_LSB +: 3] == MODE_EEPROM) ? FRBS_EEPROM : FRBS_RUN;
                FRBS_EEPROM:
                    if (eepromLoadDone || eepromLoadError)
                        state_r <= FRBS_RUN;
                FRBS_RUN:
                    if (swReset_r)
                        state_r <= FRBS_ACK;
                FRBS_ACK: state_r <= FRBS_HOLD;
                default: state_r <= FRBS_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset || pinAsserted || state_r == FRBS_HOLD)
            sinceRelease_r <= 32'h0;
        else if (sinceRelease_r != 32'hffffffff)
            sinceRelease_r <= sinceRelease_r + 32'h1;
    end

    // PLL, links and stacks.
    always_ff @(posedge clk)
    begin
        if (reset || pinAsserted || state_r == FRBS_HOLD || state_r == FRBS_DECODE)
        begin
            pllReset <= 1'b1;
            linkTrainEnable <= 1'b0;
            stackReset <= 1'b1;
            cfgRetryMode <= 1'b1;
        end
        else
        begin
            pllReset <= 1'b0;
            linkTrainEnable <= lockSync_r[1] && state_r != FRBS_PLL;
            stackReset <= 1'b0;
            cfgRetryMode <= state_r != FRBS_RUN;
        end
    end

    // Hot reset drives every port including the upstream bridge; secondary bus reset spares it. Sticky state is untouched.
    always_ff @(posedge clk)
    begin
        if (reset)
            portHotReset <= '0;
        else
        begin
            portHotReset <= {PORTS{hotReset}} | ({PORTS{secondaryBusReset}} & ~PORTS'(1));
        end
    end

    // Serial management buses.
    always_ff @(posedge clk)
    begin
        if (reset || pinAsserted || state_r == FRBS_HOLD)
        begin
            slaveBusEnable <= 1'b0;
            masterBusEnable <= 1'b0;
            slaveBusAddress <= SADDR_BASE;
            masterBusDivider <= frbs_divider(1'b0);
        end
        else
        begin
            if (state_r == FRBS_SLAVE)
            begin
                slaveBusEnable <= 1'b1;
                slaveBusAddress <= SADDR_BASE | {1'b0, boot_r[BOOT_SADDR_LSB+3], 1'b0,
                                                 boot_r[BOOT_SADDR_LSB +: 3], 1'b0};
                masterBusDivider <= frbs_divider(boot_r[BOOT_MSPD_BIT]);
            end
            if (state_r == FRBS_MASTER)
                masterBusEnable <= 1'b1;
        end
    end

    // EEPROM load control and serial bus status.
    always_ff @(posedge clk)
    begin
        if (reset || pinAsserted || state_r == FRBS_HOLD)
        begin
            eepromLoadStart <= 1'b0;
            serialBusStatus <= SBS_RESET;
            portRetrain <= '0;
        end
        else
        begin
            eepromLoadStart <= state_r == FRBS_MASTER && boot_r[BOOT_MODE_LSB +: 3] == MODE_EEPROM;
            portRetrain <= (state_r == FRBS_EEPROM) ? fullLinkRetrainWrite : '0;
            if (state_r == FRBS_EEPROM && eepromLoadError)
                serialBusStatus[SBS_ERR_W-1:0] <= eepromErrorCode;
            if (state_r == FRBS_EEPROM && (eepromLoadDone || eepromLoadError))
                serialBusStatus[SBS_DONE_BIT] <= 1'b1;
        end
    end

    // Slot clock bits take the straps at reset; software may override per port.
    always_ff @(posedge clk)
    begin
        if (reset || state_r == FRBS_DECODE)
        begin
            if (reset)
                slotClockConfig <= '0;
            else
                slotClockConfig <= {{(PORTS-1){boot_r[BOOT_CCDS_BIT]}}, boot_r[BOOT_CCUS_BIT]};
        end
        else
        begin
            for (int i = 0; i < PORTS; i++)
            begin
                if (slotClockWrite[i])
                    slotClockConfig[i] <= slotClockWriteData[i];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            switchStatus <= BOOT_RESET;
            modeReserved <= 1'b0;
            sequenceDone <= 1'b0;
            fundamentalResetCtlAck <= 1'b0;
        end
        else
        begin
            switchStatus <= boot_r;
            modeReserved <= boot_r[BOOT_MODE_LSB +: 3] != MODE_NORMAL
                            && boot_r[BOOT_MODE_LSB +: 3] != MODE_EEPROM;
            sequenceDone <= state_r == FRBS_RUN;
            fundamentalResetCtlAck <= state_r == FRBS_RUN && swReset_r;
        end
    end

    property p_link_deadline;
        @(posedge clk) disable iff (reset)
        !(linkTrainEnable == 1'b0 && state_r != FRBS_HOLD && sinceRelease_r > LINK_ACTIVE_CYC && lockSync_r[1]);
    endproperty
    a_link_deadline: assert property (p_link_deadline) else $error("link not active in time");

    property p_retry_deadline;
        @(posedge clk) disable iff (reset)
        (sinceRelease_r > CFG_RETRY_CYC) |-> !stackReset;
    endproperty
    a_retry_deadline: assert property (p_retry_deadline) else $error("stack still in reset");

    property p_boot_stable;
        @(posedge clk) disable iff (reset)
        !pinRelease |=> $stable(boot_r);
    endproperty
    a_boot_stable: assert property (p_boot_stable) else $error("boot vector changed");

    property p_boot_capture;
        @(posedge clk) disable iff (reset)
        pinRelease |=> boot_r[BOOT_MODE_LSB +: 3] == $past(modeS2_r);
    endproperty
    a_boot_capture: assert property (p_boot_capture) else $error("boot not captured");

    property p_warm_reuse;
        @(posedge clk) disable iff (reset || pinAsserted)
        (state_r == FRBS_DECODE && !pinCapture_r) |-> boot_r == switchStatus;
    endproperty
    a_warm_reuse: assert property (p_warm_reuse) else $error("warm reset resampled boot");

    property p_ack_first;
        @(posedge clk) disable iff (reset || pinAsserted)
        (state_r == FRBS_ACK) |-> fundamentalResetCtlAck && !pllReset ##1 state_r == FRBS_HOLD;
    endproperty
    a_ack_first: assert property (p_ack_first) else $error("ack missing before reset");

    property p_master_after_slave;
        @(posedge clk) disable iff (reset)
        $rose(masterBusEnable) |-> slaveBusEnable;
    endproperty
    a_master_after_slave: assert property (p_master_after_slave) else $error("master before slave");

    property p_speed;
        @(posedge clk) disable iff (reset)
        slaveBusEnable && $rose(masterBusEnable) |->
            masterBusDivider == (boot_r[BOOT_MSPD_BIT] ? 16'(MBUS_SLOW_DIV) : 16'(MBUS_FAST_DIV));
    endproperty
    a_speed: assert property (p_speed) else $error("wrong master bus rate");

    property p_done_flag;
        @(posedge clk) disable iff (reset || pinAsserted)
        (state_r == FRBS_EEPROM && eepromLoadError) |=> serialBusStatus[SBS_DONE_BIT] && state_r == FRBS_RUN;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done not set on error");

    property p_retry_during_load;
        @(posedge clk) disable iff (reset || pinAsserted)
        (state_r == FRBS_EEPROM) |=> cfgRetryMode;
    endproperty
    a_retry_during_load: assert property (p_retry_during_load) else $error("no retry during load");

    property p_pin_reset;
        @(posedge clk) disable iff (reset)
        pinAsserted |=> state_r == FRBS_HOLD ##1 pllReset;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");

endmodule // frbs_sequencer
`default_nettype wire

// >>> frbs_partner.sv
`timescale 1ns/1ps
`default_nettype none
module frbs_partner
    import frbs_pkg::*;
#(
    parameter int unsigned PORTS = 4
)
(
    input wire logic clk,
    input wire logic pllReset,
    input wire logic eepromLoadStart,
    input wire logic loadFail,
    input wire logic loadSlow,
    output logic pllLock,
    output logic eepromLoadDone,
    output logic eepromLoadError,
    output logic [SBS_ERR_W-1:0] eepromErrorCode,
    output logic [PORTS-1:0] fullLinkRetrainWrite
);
    int lockCnt = 0;
    int loadCnt = 0;
    int loadEnd;

    assign loadEnd = loadSlow ? 40 : 11;

    // Lock is lost at once under PLL reset and comes back several cycles after it.
    always_ff @(posedge clk)
    begin
        lockCnt <= pllReset ? 0 : lockCnt + 1;
        pllLock <= !pllReset && lockCnt > 6;
    end

    // The error code is forced to 0xa outside its strobe so stale values never look valid.
    always_ff @(posedge clk)
    begin
        loadCnt <= eepromLoadStart ? 1 : (loadCnt != 0 && loadCnt < loadEnd) ? loadCnt + 1 : 0;
        fullLinkRetrainWrite <= (loadCnt == 5) ? PORTS'(2) : '0;
        eepromLoadDone <= loadCnt == loadEnd && !loadFail;
        eepromLoadError <= loadCnt == loadEnd && loadFail;
        eepromErrorCode <= (loadCnt == loadEnd && loadFail) ? 4'h5 : 4'ha;
    end
endmodule // frbs_partner
`default_nettype wire

// >>> frbs_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module frbs_sequencer_tb_top
    import frbs_pkg::*;
;
    logic clk = 1'b0;
    logic reset, fundamentalResetN, commonClockDownstreamStrap, commonClockUpstreamStrap;
    logic masterBusSpeedStrap, fundamentalResetCtlWrite, hotReset, secondaryBusReset, pllLock;
    logic eepromLoadDone, eepromLoadError, loadFail, loadSlow, pllReset, linkTrainEnable;
    logic stackReset, cfgRetryMode, slaveBusEnable, masterBusEnable, eepromLoadStart;
    logic fundamentalResetCtlAck, modeReserved, sequenceDone;
    logic [2:0] operatingModeStraps;
    logic [3:0] slaveBusAddressStraps, slotClockWrite, slotClockWriteData, fullLinkRetrainWrite;
    logic [3:0] portHotReset, portRetrain, slotClockConfig, eepromErrorCode;
    logic [6:0] slaveBusAddress;
    logic [15:0] masterBusDivider;
    logic [BOOT_W-1:0] switchStatus;
    logic [4:0] serialBusStatus;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    int nRetrain = 0;

    frbs_sequencer #(.PORTS(4), .LINK_ACTIVE_CYC(200), .CFG_RETRY_CYC(200)) dut (
        .clk, .reset, .fundamentalResetN, .operatingModeStraps, .commonClockDownstreamStrap,
        .commonClockUpstreamStrap, .masterBusSpeedStrap, .slaveBusAddressStraps,
        .fundamentalResetCtlWrite, .hotReset, .secondaryBusReset, .pllLock, .slotClockWrite,
        .slotClockWriteData, .eepromLoadDone, .eepromLoadError, .eepromErrorCode,
        .fullLinkRetrainWrite, .pllReset, .linkTrainEnable, .stackReset, .cfgRetryMode,
        .portHotReset, .portRetrain, .slaveBusEnable, .slaveBusAddress, .masterBusEnable,
        .masterBusDivider, .eepromLoadStart, .fundamentalResetCtlAck, .switchStatus,
        .slotClockConfig, .serialBusStatus, .modeReserved, .sequenceDone);

    frbs_partner #(.PORTS(4)) far (
        .clk, .pllReset, .eepromLoadStart, .loadFail, .loadSlow, .pllLock, .eepromLoadDone,
        .eepromLoadError, .eepromErrorCode, .fullLinkRetrainWrite);

    always #20 clk = ~clk;

    always @(negedge clk)
        if (portRetrain === 4'h2)
            nRetrain++;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask

    task automatic check_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %0t %s got %h", $time, what, got);
        end
    endtask

    task automatic wait_done();
        for (int n = 0; n < 500 && sequenceDone !== 1'b1; n++)
            @(negedge clk);
        check_bit(sequenceDone, 1'b1, "never done");
        repeat (2) @(negedge clk);
    endtask

    task automatic pin_boot(input logic [2:0] m, input logic cd, input logic cu, input logic sp,
                            input logic [3:0] sa);
        logic seen;
        seen = 1'b0;
        nRetrain = 0;
        fundamentalResetN = 1'b0;
        operatingModeStraps = m;
        commonClockDownstreamStrap = cd;
        commonClockUpstreamStrap = cu;
        masterBusSpeedStrap = sp;
        slaveBusAddressStraps = sa;
        // The pin low time is scaled far below the board minimum to keep the run short.
        repeat (10) @(negedge clk);
        check_bit(pllReset & stackReset & cfgRetryMode, 1'b1, "not held");
        check_bit(sequenceDone, 1'b0, "done in reset");
        fundamentalResetN = 1'b1;
        repeat (5) @(negedge clk);
        commonClockDownstreamStrap = !cd;
        commonClockUpstreamStrap = !cu;
        masterBusSpeedStrap = !sp;
        slaveBusAddressStraps = ~sa;
        for (int n = 5; n < 200 && linkTrainEnable !== 1'b1; n++)
            @(negedge clk);
        check_bit(linkTrainEnable, 1'b1, "training late");
        check_bit(pllLock & !pllReset, 1'b1, "training before lock");
        for (int n = 0; n < 500 && sequenceDone !== 1'b1; n++)
        begin
            if (eepromLoadStart === 1'b1)
            begin
                seen = 1'b1;
                check_bit(cfgRetryMode, 1'b1, "no retry in load");
            end
            if (masterBusEnable === 1'b1 && slaveBusEnable !== 1'b1)
                check_bit(slaveBusEnable, 1'b1, "master first");
            @(negedge clk);
        end
        wait_done();
        check_bit(seen, m === MODE_EEPROM, "load start");
        check_vec(16'(switchStatus), 16'({sa, sp, cu, cd, m}), "boot vector");
        check_vec(16'(slotClockConfig), 16'({cd, cd, cd, cu}), "slot clock");
        check_vec(16'(slaveBusAddress), 16'({1'b0, sa[3], 1'b0, sa[2:0], 1'b0}), "slave addr");
        check_bit(slaveBusEnable & masterBusEnable, 1'b1, "bus enables");
        check_vec(masterBusDivider, sp ? 16'(MBUS_SLOW_DIV) : 16'(MBUS_FAST_DIV), "divider");
        check_bit(modeReserved, m > 3'h1, "reserved flag");
        check_vec(16'(serialBusStatus), (m === MODE_EEPROM) ? {11'h0, 1'b1, loadFail ? 4'h5 : 4'h0}
                  : 16'h0, "load status");
        check_vec(16'(nRetrain), (m === MODE_EEPROM) ? 16'h1 : 16'h0, "retrain");
        check_bit(cfgRetryMode, 1'b0, "retry stuck");
        $display("pin boot mode %0d fail %0d ended", m, loadFail);
    endtask

    task automatic warm_reset();
        logic [BOOT_W-1:0] was;
        logic seen;
        was = switchStatus;
        seen = 1'b0;
        commonClockDownstreamStrap = !commonClockDownstreamStrap;
        slaveBusAddressStraps = ~slaveBusAddressStraps;
        fundamentalResetCtlWrite = 1'b1;
        @(negedge clk);
        fundamentalResetCtlWrite = 1'b0;
        for (int n = 0; n < 4 && fundamentalResetCtlAck !== 1'b1; n++)
            @(negedge clk);
        check_bit(fundamentalResetCtlAck, 1'b1, "no ack");
        check_bit(pllReset, 1'b0, "reset before ack");
        for (int n = 0; n < 8; n++)
        begin
            seen = seen | (pllReset === 1'b1);
            @(negedge clk);
        end
        check_bit(seen, 1'b1, "no warm restart");
        wait_done();
        check_vec(16'(switchStatus), 16'(was), "warm resampled");
        $display("warm reset ended");
    endtask

    task automatic hot_reset();
        logic [3:0] exp;
        logic [BOOT_W-1:0] was;
        was = switchStatus;
        hotReset = 1'b1;
        repeat (3) @(negedge clk);
        check_vec(16'(portHotReset), 16'hf, "hot fanout");
        hotReset = 1'b0;
        secondaryBusReset = 1'b1;
        repeat (3) @(negedge clk);
        check_vec(16'(portHotReset), 16'he, "upstream hit");
        secondaryBusReset = 1'b0;
        repeat (3) @(negedge clk);
        check_vec(16'(portHotReset), 16'h0, "hot stuck");
        check_vec(16'(switchStatus), 16'(was), "sticky lost");
        exp = slotClockConfig ^ 4'h4;
        slotClockWriteData = exp;
        slotClockWrite = 4'h4;
        @(negedge clk);
        slotClockWrite = 4'h0;
        repeat (2) @(negedge clk);
        check_vec(16'(slotClockConfig), 16'(exp), "slot override");
        $display("hot reset ended");
    endtask

    initial
    begin
        reset = 1'b1;
        fundamentalResetN = 1'b0;
        operatingModeStraps = 3'h0;
        {commonClockDownstreamStrap, commonClockUpstreamStrap, masterBusSpeedStrap} = 3'h0;
        slaveBusAddressStraps = 4'h0;
        {fundamentalResetCtlWrite, hotReset, secondaryBusReset, loadFail, loadSlow} = 5'h00;
        slotClockWrite = 4'h0;
        slotClockWriteData = 4'h0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        for (int m = 0; m < 8; m++)
            pin_boot(3'(m), m[0], m[1], m[2], 4'(m * 5));
        loadSlow = 1'b1;
        pin_boot(MODE_EEPROM, 1'b1, 1'b0, 1'b1, 4'ha);
        loadSlow = 1'b0;
        loadFail = 1'b1;
        pin_boot(MODE_EEPROM, 1'b0, 1'b1, 1'b0, 4'h5);
        loadFail = 1'b0;
        warm_reset();
        hot_reset();
        tally_and_finish();
    end
endmodule // frbs_sequencer_tb_top
`default_nettype wire
